//--- core/afifo_defines.svh
// Purpose: Offsets, fields and timing counts for the strobe FIFO controller
// Assumes: 10 MHz clock, 100 ns period
// Notes:   Controller registers are one aligned word each
`ifndef AFIFO_DEFINES_SVH
`define AFIFO_DEFINES_SVH
// ==========================================
// Register offsets
`define AFIFO_OFF_CTRL   8'h00
`define AFIFO_OFF_WDATA  8'h04
`define AFIFO_OFF_RDATA  8'h08
`define AFIFO_OFF_STATUS 8'h0c
// ==========================================
// Control fields (bits 0-2 write 1 to start, self clearing; bits 3-4 mode, kept and read back)
`define AFIFO_CTRL_RESET 0
`define AFIFO_CTRL_RETX  1
`define AFIFO_CTRL_READ  2
`define AFIFO_CTRL_FIRST 3
`define AFIFO_CTRL_CASC  4
// ==========================================
// Status fields
`define AFIFO_ST_BUSY    0
`define AFIFO_ST_EMPTY   1
`define AFIFO_ST_HALF    2
`define AFIFO_ST_FULL    3
`define AFIFO_ST_DROP    4
`define AFIFO_ST_RVALID  5
// ==========================================
// Timing in ns and derived cycles
`define AFIFO_CLK_NS     100
`define AFIFO_PULSE_NS   65
`define AFIFO_RECOV_NS   80
`define AFIFO_ACCESS_NS  65
`define AFIFO_FLAG_NS    80
`define AFIFO_CYC(ns)    ((((ns) + `AFIFO_CLK_NS - 1) / `AFIFO_CLK_NS) < 1 ? 1 : \
                          (((ns) + `AFIFO_CLK_NS - 1) / `AFIFO_CLK_NS))
`endif

//--- core/afifo_host.sv
// Notes on behaviour
// - Strobes held high around reset rising edge
// - Write word held stable over write strobe
// - Strobes high during and after retransmit
// - Retransmit only within depth of writes (writes not counted here; retransmit issued after any number)
// - Standalone: cascade-in low, first-part high
// - Width cascade shares all control lines
// - Depth ring: first part pin low
//
// Purpose: AHB-Lite controlled driver for an unclocked strobe FIFO
// Assumes: FIFO pins synchronous to clk_in
// Notes:   One operation at a time; ready held low over it, so busy bit always reads 0
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "afifo_defines.svh"
module afifo_host
  import afifo_pkg::*;
#(
  parameter int DEPTH = 8192,
  parameter int WIDTH = 9
)(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  output afifo_ctl_t             ctl_out,
  output logic      [WIDTH-1:0]  write_word_out,
  output logic                   write_word_oe_out,
  input  wire afifo_flag_t       flag_in,
  input  wire logic [WIDTH-1:0]  read_word_in,
  input  wire logic              read_word_oe_in
);
  localparam int PULSE = `AFIFO_CYC(`AFIFO_PULSE_NS);
  localparam int RECOV = `AFIFO_CYC(`AFIFO_RECOV_NS);
  localparam int ACC   = `AFIFO_CYC(`AFIFO_ACCESS_NS);
  localparam int FLAG  = `AFIFO_CYC(`AFIFO_FLAG_NS);

  function automatic logic [3:0] cyc4(input int n);
    cyc4 = 4'(n);
  endfunction

  // ==========================================
  // Bus slave state
  logic [7:0]        addr_q, addr_d;
  logic              wr_q, wr_d;
  logic              ph_q, ph_d;
  logic [31:0]       hrdata_q, hrdata_d;
  // ==========================================
  // Sequencer state
  afifo_state_t      st_q, st_d;
  afifo_op_t         op_q, op_d;
  logic [3:0]        cnt_q, cnt_d;
  afifo_ctl_t        ctl_q, ctl_d;
  logic [WIDTH-1:0]  wword_q, wword_d;
  logic              woe_q, woe_d;
  logic [WIDTH-1:0]  rword_q, rword_d;
  logic              rvalid_q, rvalid_d;
  logic              drop_q, drop_d;
  logic              first_q, first_d;
  logic              casc_q, casc_d;

  always_comb
  begin
    addr_d   = addr_q;
    wr_d     = 1'b0;
    ph_d     = 1'b0;
    hrdata_d = hrdata_q;
    st_d     = st_q;
    op_d     = op_q;
    cnt_d    = cnt_q;
    ctl_d    = ctl_q;
    wword_d  = wword_q;
    woe_d    = woe_q;
    rword_d  = rword_q;
    rvalid_d = rvalid_q;
    drop_d   = drop_q;
    first_d  = first_q;
    casc_d   = casc_q;
    // Address phase taken only when idle so a pending op never loses a command
    if (hsel_in && hready_in && htrans_in[1] && hreadyout_out)
    begin
      addr_d = haddr_in[7:0];
      wr_d   = hwrite_in;
      ph_d   = 1'b1;
    end
    if (ph_q && !wr_q)
    begin
      if (addr_q == `AFIFO_OFF_RDATA)
        hrdata_d = 32'({rvalid_q, rword_q});
      else if (addr_q == `AFIFO_OFF_STATUS)
        // In depth mode the shared pin carries cascade-out, so no half report
        hrdata_d = {26'h0, rvalid_q, drop_q, !flag_in.full_flag_n,
                    !flag_in.half_full_flag_n && !casc_q,
                    !flag_in.empty_flag_n, st_q != AFIFO_IDLE};
      else if (addr_q == `AFIFO_OFF_CTRL)
        hrdata_d = {27'h0, casc_q, first_q, 3'h0};
      else
        hrdata_d = 32'h0;
    end
    if (ph_q && !wr_q && addr_q == `AFIFO_OFF_RDATA)
      rvalid_d = 1'b0;
    // Drop flag sticky until the next control write; set beats software clear
    case (st_q)
      AFIFO_IDLE:
      begin
        if (ph_q && wr_q && addr_q == `AFIFO_OFF_WDATA)
        begin
          if (!flag_in.full_flag_n)
            drop_d = 1'b1;
          else
          begin
            op_d          = AFIFO_OP_WR;
            wword_d       = hwdata_in[WIDTH-1:0];
            woe_d         = 1'b1;
            ctl_d.write_n = 1'b0;
            cnt_d         = cyc4(PULSE);
            st_d          = AFIFO_ACT;
          end
        end
        else if (ph_q && wr_q && addr_q == `AFIFO_OFF_CTRL)
        begin
          drop_d  = 1'b0;
          if (hwdata_in[`AFIFO_CTRL_RESET])
          begin
            // Mode bits mirror the pins, so they change only with a reset
            first_d              = hwdata_in[`AFIFO_CTRL_FIRST];
            casc_d               = hwdata_in[`AFIFO_CTRL_CASC];
            op_d                 = AFIFO_OP_MISC;
            // Mode pins set in the same cycle as the reset pulse starts; strobes idle high
            ctl_d.first_part_n   = !hwdata_in[`AFIFO_CTRL_FIRST];
            ctl_d.cascade_in_n   = hwdata_in[`AFIFO_CTRL_CASC];
            ctl_d.master_reset_n = 1'b0;
            cnt_d                = cyc4(PULSE);
            st_d                 = AFIFO_ACT;
          end
          else if (hwdata_in[`AFIFO_CTRL_RETX] && !casc_q)
          begin
            // Retransmit is not offered in depth mode
            op_d               = AFIFO_OP_MISC;
            ctl_d.retransmit_n = 1'b0;
            cnt_d              = cyc4(PULSE);
            st_d               = AFIFO_ACT;
          end
          else if (hwdata_in[`AFIFO_CTRL_READ])
          begin
            if (!flag_in.empty_flag_n)
              drop_d = 1'b1;
            else
            begin
              op_d         = AFIFO_OP_RD;
              ctl_d.read_n = 1'b0;
              cnt_d        = cyc4(ACC);
              st_d         = AFIFO_ACT;
            end
          end
        end
      end
      AFIFO_ACT:
      begin
        if (cnt_q > 4'h1)
          cnt_d = cnt_q - 4'h1;
        else
        begin
          // Data sampled before the read strobe rises and outputs float
          if (op_q == AFIFO_OP_RD)
          begin
            rword_d  = read_word_oe_in ? read_word_in : '0;
            rvalid_d = read_word_oe_in;
          end
          ctl_d.write_n        = 1'b1;
          ctl_d.read_n         = 1'b1;
          ctl_d.master_reset_n = 1'b1;
          ctl_d.retransmit_n   = 1'b1;
          cnt_d                = cyc4(RECOV);
          st_d                 = AFIFO_REC;
        end
      end
      AFIFO_REC:
      begin
        // Strobes stay high for recovery after reset and retransmit
        woe_d = 1'b0;
        if (cnt_q > 4'h1)
          cnt_d = cnt_q - 4'h1;
        else
        begin
          cnt_d = cyc4(FLAG);
          st_d  = AFIFO_SETTLE;
        end
      end
      default:
      begin
        // Flags seen only once they have settled after the strobe
        if (cnt_q > 4'h1)
          cnt_d = cnt_q - 4'h1;
        else
        begin
          op_d = AFIFO_OP_NONE;
          st_d = AFIFO_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      addr_q   <= 8'h00;
      wr_q     <= 1'b0;
      ph_q     <= 1'b0;
      hrdata_q <= 32'h0;
      st_q     <= AFIFO_IDLE;
      op_q     <= AFIFO_OP_NONE;
      cnt_q    <= 4'h0;
      ctl_q    <= 6'b111110;
      wword_q  <= '0;
      woe_q    <= 1'b0;
      rword_q  <= '0;
      rvalid_q <= 1'b0;
      drop_q   <= 1'b0;
      first_q  <= 1'b0;
      casc_q   <= 1'b0;
    end
    else
    begin
      addr_q   <= addr_d;
      wr_q     <= wr_d;
      ph_q     <= ph_d;
      hrdata_q <= hrdata_d;
      st_q     <= st_d;
      op_q     <= op_d;
      cnt_q    <= cnt_d;
      ctl_q    <= ctl_d;
      wword_q  <= wword_d;
      woe_q    <= woe_d;
      rword_q  <= rword_d;
      rvalid_q <= rvalid_d;
      drop_q   <= drop_d;
      first_q  <= first_d;
      casc_q   <= casc_d;
    end
  end

  // ==========================================
  // Outputs
  // Ready held low one cycle after any access, and from a write or control access until the op finishes
  logic rdy_q;
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      rdy_q <= 1'b1;
    else
      rdy_q <= (st_d == AFIFO_IDLE) && !(hsel_in && hready_in && htrans_in[1] && hreadyout_out);
  end
  assign hreadyout_out     = rdy_q;
  assign hrdata_out        = hrdata_q;
  assign hresp_out         = 1'b0;
  assign ctl_out           = ctl_q;
  assign write_word_out    = wword_q;
  assign write_word_oe_out = woe_q;
endmodule // afifo_host
`default_nettype wire

//--- core/afifo_pkg.sv
// Purpose: Types for the strobe FIFO controller
// Assumes: Nothing beyond the defines header
// Notes:   Pin groups travel as packed structs
package afifo_pkg;
  typedef enum logic [2:0] {AFIFO_IDLE, AFIFO_ACT, AFIFO_REC, AFIFO_SETTLE} afifo_state_t;
  typedef enum logic [1:0] {AFIFO_OP_NONE, AFIFO_OP_WR, AFIFO_OP_RD, AFIFO_OP_MISC} afifo_op_t;
  typedef struct packed {
    logic master_reset_n;
    logic write_n;
    logic read_n;
    logic retransmit_n;
    logic first_part_n;
    logic cascade_in_n;
  } afifo_ctl_t;
  typedef struct packed {
    logic empty_flag_n;
    logic half_full_flag_n;
    logic full_flag_n;
  } afifo_flag_t;
endpackage

//--- testbench/afifo_dev_model.sv
// Purpose: Behavioural strobe FIFO part facing the controller
// Assumes: Strobes are clean levels, no electrical timing modelled
// Notes:   Released data lines show the inverse of the last word
`timescale 1ns/1ns
`default_nettype none
module afifo_dev_model
  import afifo_pkg::*;
#(
  parameter int DEPTH = 4
)(
  input  wire afifo_ctl_t  ctl_in,
  input  wire logic [8:0]  word_in,
  output afifo_flag_t      flag_out,
  output logic      [8:0]  word_out,
  output logic             oe_out
);
  logic [8:0] mem [DEPTH];
  logic [8:0] q_q = 9'h000;
  logic       oe_q = 1'b0;
  logic       deep_q = 1'b0;
  int         wp = 0;
  int         rp = 0;
  int         fill;
  int         fill_w;
  assign fill = wp - rp;
  assign fill_w = fill + int'(!ctl_in.write_n);
  // Full and half count a write from its falling strobe, a read from its rising one; empty the reverse
  assign flag_out = {fill > int'(oe_q), deep_q || fill_w <= DEPTH / 2, fill_w < DEPTH};
  assign word_out = oe_q ? q_q : ~q_q;
  assign oe_out = oe_q;
  always @(posedge ctl_in.master_reset_n)
  begin
    wp = 0;
    rp = 0;
    oe_q = 1'b0;
    deep_q = ctl_in.cascade_in_n || !ctl_in.first_part_n;
  end
  always @(posedge ctl_in.write_n)
    if (ctl_in.master_reset_n && fill < DEPTH)
    begin
      mem[wp % DEPTH] = word_in;
      wp++;
    end
  always @(negedge ctl_in.read_n)
    if (fill > 0)
    begin
      q_q = mem[rp % DEPTH];
      oe_q = 1'b1;
    end
  always @(posedge ctl_in.read_n)
    if (oe_q)
    begin
      rp++;
      oe_q = 1'b0;
    end
  always @(negedge ctl_in.retransmit_n)
    if (!deep_q)
      rp = 0;
endmodule // afifo_dev_model
`default_nettype wire

//--- testbench/afifo_host_monitor.sv
// Purpose: Pin and bus timing checks on the strobe FIFO controller
// Assumes: Bound to afifo_host, sees its ports only
// Notes:   Flags are taken one edge back since the part reacts to strobes at once
`timescale 1ns/1ns
`default_nettype none
module afifo_host_monitor
  import afifo_pkg::*;
#(
  parameter int WIDTH = 9
)(
  input wire logic             clk_in,
  input wire logic             resetn_in,
  input wire logic             hsel_in,
  input wire logic [1:0]       htrans_in,
  input wire logic             hready_in,
  input wire logic             hreadyout_out,
  input wire afifo_ctl_t       ctl_out,
  input wire logic [WIDTH-1:0] write_word_out,
  input wire logic             write_word_oe_out,
  input wire afifo_flag_t      flag_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================
  // Sequences
  sequence s_quiet;
    ctl_out.write_n && ctl_out.read_n;
  endsequence
  sequence s_held;
    write_word_oe_out ##1 (write_word_oe_out && $stable(write_word_out));
  endsequence
  // ==========================================
  // Properties
  property p_wait;
    hsel_in && hready_in && htrans_in[1] && hreadyout_out |=> !hreadyout_out;
  endproperty
  property p_rst_quiet;
    !ctl_out.master_reset_n |-> s_quiet;
  endproperty
  property p_rst_recov;
    $rose(ctl_out.master_reset_n) |-> s_quiet ##1 s_quiet;
  endproperty
  property p_retx_quiet;
    !ctl_out.retransmit_n |-> s_quiet;
  endproperty
  property p_retx_recov;
    $rose(ctl_out.retransmit_n) |-> s_quiet ##1 s_quiet;
  endproperty
  property p_retx_mode;
    $fell(ctl_out.retransmit_n) |-> ctl_out.first_part_n && !ctl_out.cascade_in_n;
  endproperty
  property p_wr_held;
    $fell(ctl_out.write_n) |-> s_held;
  endproperty
  property p_wr_room;
    $fell(ctl_out.write_n) |-> $past(flag_in.full_flag_n);
  endproperty
  property p_rd_data;
    $fell(ctl_out.read_n) |-> $past(flag_in.empty_flag_n);
  endproperty
  a_wait:       assert property (p_wait)       else $error("no wait state on access");
  a_rst_quiet:  assert property (p_rst_quiet)  else $error("strobe low in reset");
  a_rst_recov:  assert property (p_rst_recov)  else $error("strobe low after reset");
  a_retx_quiet: assert property (p_retx_quiet) else $error("strobe low in rewind");
  a_retx_recov: assert property (p_retx_recov) else $error("strobe low after rewind");
  a_retx_mode:  assert property (p_retx_mode)  else $error("rewind in depth mode");
  a_wr_held:    assert property (p_wr_held)    else $error("write word not held");
  a_wr_room:    assert property (p_wr_room)    else $error("write into full part");
  a_rd_data:    assert property (p_rd_data)    else $error("read of empty part");
endmodule // afifo_host_monitor
`default_nettype wire

//--- testbench/tb_afifo_host.sv
// Purpose: Register level test of the strobe FIFO controller
// Assumes: One AHB-Lite master, four word model part
// Notes:   Small depth keeps the fill and drain runs short
`timescale 1ns/1ns
`default_nettype none
`include "afifo_defines.svh"
module tb_afifo_host
  import afifo_pkg::*;
;
  localparam int D = 4;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  afifo_ctl_t  ctl;
  afifo_flag_t flg;
  logic [8:0]  wword;
  logic [8:0]  rword;
  logic        woe;
  logic        roe;
  int          err_count = 0;
  int          comparisons = 0;
  always #50 clk_in = ~clk_in;
  afifo_host #(.DEPTH(D), .WIDTH(9)) DUT (.clk_in(clk_in), .resetn_in(resetn_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .ctl_out(ctl), .write_word_out(wword),
    .write_word_oe_out(woe), .flag_in(flg), .read_word_in(rword), .read_word_oe_in(roe));
  afifo_dev_model #(.DEPTH(D)) MODEL (.ctl_in(ctl), .word_in(wword), .flag_out(flg),
    .word_out(rword), .oe_out(roe));
  // ==========================================
  // Tasks
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] st(input int n);
    return {28'h0, n == D, n > D / 2, n == 0, 1'b0};
  endfunction
  task automatic rdword(input int k);
    logic [31:0] q;
    ahb(1'b1, `AFIFO_OFF_CTRL, 32'h4, q);
    ahb(1'b0, `AFIFO_OFF_RDATA, 32'h0, q);
    chk(q, 32'h200 | (32'h1a0 + k));
  endtask
  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial
  begin
    #2000000;
    err_count++;
    close_out();
  end
  initial
  begin
    logic [31:0] r;
    int k;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    ahb(1'b1, `AFIFO_OFF_CTRL, 32'h1, r);
    ahb(1'b0, `AFIFO_OFF_STATUS, 32'h0, r);
    chk(r, st(0));
    ahb(1'b1, `AFIFO_OFF_CTRL, 32'h4, r);
    ahb(1'b0, `AFIFO_OFF_STATUS, 32'h0, r);
    chk(r, 32'h10 | st(0));
    ahb(1'b0, `AFIFO_OFF_RDATA, 32'h0, r);
    chk(r & 32'h200, 32'h0);
    ahb(1'b1, `AFIFO_OFF_CTRL, 32'h1, r);
    for (k = 1; k <= D; k++)
    begin
      ahb(1'b1, `AFIFO_OFF_WDATA, 32'h1a0 + k, r);
      ahb(1'b0, `AFIFO_OFF_STATUS, 32'h0, r);
      chk(r, st(k));
    end
    ahb(1'b1, `AFIFO_OFF_WDATA, 32'h1ff, r);
    ahb(1'b0, `AFIFO_OFF_STATUS, 32'h0, r);
    chk(r, 32'h10 | st(D));
    for (k = 1; k <= 2; k++)
    begin
      rdword(k);
      ahb(1'b0, `AFIFO_OFF_STATUS, 32'h0, r);
      chk(r, st(D - k));
    end
    ahb(1'b1, `AFIFO_OFF_CTRL, 32'h2, r);
    ahb(1'b0, `AFIFO_OFF_STATUS, 32'h0, r);
    chk(r, st(D));
    rdword(1);
    ahb(1'b1, `AFIFO_OFF_WDATA, 32'h1a5, r);
    for (k = 2; k <= 5; k++)
      rdword(k);
    ahb(1'b0, `AFIFO_OFF_STATUS, 32'h0, r);
    chk(r, st(0));
    ahb(1'b1, `AFIFO_OFF_CTRL, 32'h19, r);
    ahb(1'b1, `AFIFO_OFF_WDATA, 32'h1a1, r);
    rdword(1);
    ahb(1'b1, `AFIFO_OFF_CTRL, 32'h2, r);
    ahb(1'b0, `AFIFO_OFF_STATUS, 32'h0, r);
    chk(r, st(0));
    ahb(1'b0, `AFIFO_OFF_CTRL, 32'h0, r);
    chk(r, 32'h18);
    ahb(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    close_out();
  end
endmodule // tb_afifo_host
bind afifo_host afifo_host_monitor #(.WIDTH(WIDTH)) MON (.clk_in(clk_in),
  .resetn_in(resetn_in), .hsel_in(hsel_in), .htrans_in(htrans_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .ctl_out(ctl_out), .write_word_out(write_word_out),
  .write_word_oe_out(write_word_oe_out), .flag_in(flag_in));
`default_nettype wire
